// ### core/wmp_dummy_unused_placeholder_not_needed.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### core/wmp_playback.v
// How it works
// RULE1: Each sample word is 16 bits: 14 analog bits and two marker bits.
// RULE2: Raw words are unsigned; the two lowest bits are the markers.
// RULE3: Raw 0 gives negative full scale, 65535 positive, linear between.
// RULE4: Marker code 0 none, 1 first, 2 second, 3 both markers high.
// RULE5: Markers leave in the same cycle as the analog value of their word.
// RULE6: Waveforms flagged without marker content play with markers held zero.
// RULE7: Add mode sums two analog streams and merges their markers.
// RULE8: Merged marker bits are the OR of the two operand marker bits.
// RULE9: Four trigger channels, each routed to one selectable source.
// RULE10: Sources include front trigger connectors and internal units.
// RULE11: Wait-for-trigger stalls instructions until the selected channel edge.
// RULE12: Host supplies analog values within minus one to plus one.
// RULE13: Play only starts output; later instructions run during playback.
// RULE14: Set-trigger drives four outputs, bit 0 to output 1, bit 3 to 4.
// RULE15: Playback length is counted in blocks of 16 samples.
// RULE16: Queued waveforms follow back to back with no gap cycle.
`timescale 1ns/1ps
`default_nettype none
`include "wmp_playback_consts.vh"

module wmp_playback (
   input  wire        core_clk,
   input  wire        rst_n,
   input  wire        clkEn,
   input  wire        cmdValid,
   output wire        cmdReady,
   input  wire [1:0]  cmdOp,
   input  wire [15:0] cmdArg,
   input  wire [15:0] sampleA,
   input  wire        sampleAValid,
   output wire        sampleAReady,
   input  wire [15:0] sampleB,
   input  wire        sampleBValid,
   output wire        sampleBReady,
   input  wire [7:0]  trigSources,
   input  wire [11:0] trigSelect,
   input  wire [3:0]  trigFalling,
   output reg  [13:0] dacCode_q,
   output reg  [1:0]  markers_q,
   output reg         sampleValid_q,
   output reg  [3:0]  trigOut_q,
   output wire        busy,
   output wire        waitingTrig
);

   // ----------------------------------------------------------------
   // Sequencer states
   // ----------------------------------------------------------------
   localparam [1:0] ST_RUN       = 2'h0;
   localparam [1:0] ST_WAIT_TRIG = 2'h1;
   localparam [1:0] ST_WAIT_WAVE = 2'h2;

   // ----------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------
   // Offset binary to two's complement: flipping the top bit
   // maps code 0 to the most negative level
   function [13:0] toSigned;
      input [15:0] word;
      begin
         toSigned = {~word[`WMP_WORD_MSB], word[`WMP_WORD_MSB-1:`WMP_ANALOG_LSB]}; // [RULE2] [RULE3]
      end
   endfunction

   // Saturating sum, clipping instead of wrapping past full scale
   function [13:0] addSat;
      input [13:0] a;
      input [13:0] b;
      reg   [14:0] sum;
      begin
         sum = {a[13], a} + {b[13], b};
         if (sum[14] != sum[13]) begin
            addSat = sum[14] ? `WMP_SAT_NEG : `WMP_SAT_POS;
         end else begin
            addSat = sum[13:0];
         end
      end
   endfunction

   // Sample count minus one of a play length given in blocks
   // Whole blocks only, so a join never leaves a partial block
   function [15:0] lenToCount;
      input [11:0] blocks;
      reg   [15:0] samples;
      begin
         samples    = {4'h0, blocks} << `WMP_BLOCK_SHIFT;
         lenToCount = samples - 16'h0001; // [RULE15]
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg  [1:0]  state_q;
   reg  [1:0]  waitChan_q;
   reg         active_q;
   reg         curAdd_q;
   reg         curNoMark_q;
   reg  [15:0] cnt_q;
   reg         pendValid_q;
   reg         pendAdd_q;
   reg         pendNoMark_q;
   reg  [11:0] pendLen_q;
   reg  [7:0]  srcMeta_q;
   reg  [7:0]  srcSync_q;
   reg  [3:0]  chanPrev_q;

   reg  [3:0]  chanLevel;
   reg  [3:0]  chanEdge;
   reg  [13:0] mergedAnalog;
   reg  [1:0]  mergedMarkers;
   reg  [1:0]  markA;
   reg  [1:0]  markB;
   integer     ch;

   wire        cmdTake;
   wire        playCmd;
   wire        lenNonZero;
   wire        pop;
   wire        lastPop;
   wire        startNow;
   wire        queueCmd;
   wire        loadPend;

   // ----------------------------------------------------------------
   // Handshakes
   // ----------------------------------------------------------------
   // A second play only stalls when the one-deep queue is taken
   assign cmdReady = clkEn & (state_q == ST_RUN) &
                     ~((cmdOp == `WMP_OP_PLAY_WAVEFORM) & pendValid_q); // [RULE13]
   assign cmdTake    = cmdValid & cmdReady;
   assign playCmd    = cmdTake & (cmdOp == `WMP_OP_PLAY_WAVEFORM);
   assign lenNonZero = |cmdArg[`WMP_ARG_LEN_MSB:0];

   // Ready of one stream does not look at its own valid
   assign sampleAReady = clkEn & active_q & (~curAdd_q | sampleBValid);
   assign sampleBReady = clkEn & active_q & curAdd_q & sampleAValid; // [RULE7]
   assign pop          = sampleAReady & sampleAValid;
   assign lastPop      = pop & (cnt_q == `WMP_CNT_RST);

   // Next waveform starts on the cycle after the last word: no gap
   assign startNow = playCmd & lenNonZero & (~active_q | (lastPop & ~pendValid_q)); // [RULE16]
   assign queueCmd = playCmd & lenNonZero & ~startNow;
   assign loadPend = lastPop & pendValid_q; // [RULE16]

   // Busy covers the queued play as well
   assign busy        = active_q | pendValid_q;
   assign waitingTrig = (state_q == ST_WAIT_TRIG);

   // ----------------------------------------------------------------
   // Trigger channels
   // ----------------------------------------------------------------
   always @* begin
      chanLevel = 4'h0;
      chanEdge  = 4'h0;
      for (ch = 0; ch < 4; ch = ch + 1) begin
         // Compared with the level of the previous enabled cycle
         chanLevel[ch] = srcSync_q[trigSelect[ch*3 +: 3]]; // [RULE9] [RULE10]
         if (trigFalling[ch]) begin
            chanEdge[ch] = chanPrev_q[ch] & ~chanLevel[ch];
         end else begin
            chanEdge[ch] = ~chanPrev_q[ch] & chanLevel[ch];
         end
      end
   end

   // ----------------------------------------------------------------
   // Sample merge
   // ----------------------------------------------------------------
   always @* begin
      markA = sampleA[`WMP_MARKER_MSB:0]; // [RULE1] [RULE2]
      markB = curAdd_q ? sampleB[`WMP_MARKER_MSB:0] : `WMP_MARKER_RST;
      if (curAdd_q) begin
         mergedAnalog = addSat(toSigned(sampleA), toSigned(sampleB)); // [RULE7]
      end else begin
         mergedAnalog = toSigned(sampleA);
      end
      // Bit 0 drives marker one and bit 1 marker two
      mergedMarkers = markA | markB; // [RULE4] [RULE8]
      // Strip wins over the merge, add mode included
      if (curNoMark_q) begin
         mergedMarkers = `WMP_MARKER_RST; // [RULE6]
      end
   end

   // ----------------------------------------------------------------
   // Synchroniser and output stage
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         srcMeta_q     <= 8'h00;
         srcSync_q     <= 8'h00;
         chanPrev_q    <= 4'h0;
         dacCode_q     <= `WMP_DAC_RST;
         markers_q     <= `WMP_MARKER_RST;
         sampleValid_q <= 1'b0;
      end else if (clkEn) begin
         // Two stages before any trigger logic reads a source
         srcMeta_q     <= trigSources;
         srcSync_q     <= srcMeta_q;
         chanPrev_q    <= chanLevel;
         sampleValid_q <= pop;
         if (pop) begin
            // Both fields load together so they stay sample aligned
            dacCode_q <= mergedAnalog;  // [RULE5]
            markers_q <= mergedMarkers; // [RULE5]
         end
      end
   end

   // ----------------------------------------------------------------
   // Playback control
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q     <= 1'b0;
         curAdd_q     <= 1'b0;
         curNoMark_q  <= 1'b0;
         cnt_q        <= `WMP_CNT_RST;
         pendValid_q  <= 1'b0;
         pendAdd_q    <= 1'b0;
         pendNoMark_q <= 1'b0;
         pendLen_q    <= 12'h000;
      end else if (clkEn) begin
         if (startNow) begin
            active_q    <= 1'b1; // [RULE13]
            curAdd_q    <= cmdArg[`WMP_ARG_ADD_BIT];
            curNoMark_q <= cmdArg[`WMP_ARG_NOMARK_BIT];
            cnt_q       <= lenToCount(cmdArg[`WMP_ARG_LEN_MSB:0]); // [RULE15]
         end else if (loadPend) begin
            curAdd_q    <= pendAdd_q;
            curNoMark_q <= pendNoMark_q;
            cnt_q       <= lenToCount(pendLen_q); // [RULE16]
            pendValid_q <= 1'b0;
         end else if (lastPop) begin
            // Nothing queued: the stream goes idle after this word
            active_q <= 1'b0;
         end else if (pop) begin
            cnt_q <= cnt_q - 16'h0001;
         end
         if (queueCmd) begin
            pendValid_q  <= 1'b1; // [RULE13]
            pendAdd_q    <= cmdArg[`WMP_ARG_ADD_BIT];
            pendNoMark_q <= cmdArg[`WMP_ARG_NOMARK_BIT];
            pendLen_q    <= cmdArg[`WMP_ARG_LEN_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Instruction sequencer
   // ----------------------------------------------------------------
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= ST_RUN;
         waitChan_q <= 2'h0;
         trigOut_q  <= `WMP_TRIG_OUT_RST;
      end else if (clkEn) begin
         case (state_q)
            ST_RUN: begin
               if (cmdTake) begin
                  case (cmdOp)
                     `WMP_OP_WAIT_DIG_TRIGGER: begin
                        state_q    <= ST_WAIT_TRIG; // [RULE11]
                        waitChan_q <= cmdArg[`WMP_ARG_CHAN_MSB:0];
                     end
                     `WMP_OP_SET_TRIG_OUTPUTS: begin
                        trigOut_q <= cmdArg[`WMP_ARG_TRIG_MSB:0]; // [RULE14]
                     end
                     `WMP_OP_WAIT_WAVE_DONE: begin
                        state_q <= ST_WAIT_WAVE;
                     end
                     default: begin
                        // Play is handled by the playback control block
                        state_q <= ST_RUN;
                     end
                  endcase
               end
            end
            ST_WAIT_TRIG: begin
               // Edge seen only after entry; earlier edges are not stored
               if (chanEdge[waitChan_q]) begin
                  state_q <= ST_RUN; // [RULE11]
               end
            end
            ST_WAIT_WAVE: begin
               // Releases once nothing plays and nothing is queued
               if (!active_q && !pendValid_q) begin
                  state_q <= ST_RUN;
               end
            end
            default: begin
               state_q <= ST_RUN;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// ### core/wmp_playback_consts.vh
`ifndef WMP_PLAYBACK_CONSTS_VH
`define WMP_PLAYBACK_CONSTS_VH

// ----------------------------------------------------------------
// Instruction opcodes
// ----------------------------------------------------------------
`define WMP_OP_PLAY_WAVEFORM     2'h0
`define WMP_OP_WAIT_DIG_TRIGGER  2'h1
`define WMP_OP_SET_TRIG_OUTPUTS  2'h2
`define WMP_OP_WAIT_WAVE_DONE    2'h3

// ----------------------------------------------------------------
// Play argument fields
// ----------------------------------------------------------------
`define WMP_ARG_ADD_BIT          15
`define WMP_ARG_NOMARK_BIT       14
`define WMP_ARG_LEN_MSB          11
`define WMP_ARG_CHAN_MSB         1
`define WMP_ARG_TRIG_MSB         3

// ----------------------------------------------------------------
// Sample word layout
// ----------------------------------------------------------------
`define WMP_WORD_MSB             15
`define WMP_ANALOG_LSB           2
`define WMP_MARKER_MSB           1
`define WMP_BLOCK_SHIFT          4

// ----------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------
`define WMP_MARKER_RST           2'h0
`define WMP_TRIG_OUT_RST         4'h0
`define WMP_DAC_RST              14'h0000
`define WMP_CNT_RST              16'h0000
`define WMP_SAT_POS              14'h1fff
`define WMP_SAT_NEG              14'h2000
`define WMP_NUM_SOURCES          8

`endif

// ### testbench/wmp_playback_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "wmp_playback_consts.vh"
module wmp_playback_chk (
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic        cmdValid,
   input wire logic        cmdReady,
   input wire logic [1:0]  cmdOp,
   input wire logic [15:0] cmdArg,
   input wire logic [15:0] sampleA,
   input wire logic        sampleAValid,
   input wire logic        sampleAReady,
   input wire logic [15:0] sampleB,
   input wire logic        sampleBValid,
   input wire logic        sampleBReady,
   input wire logic [13:0] dacCode_q,
   input wire logic [1:0]  markers_q,
   input wire logic        sampleValid_q,
   input wire logic [3:0]  trigOut_q,
   input wire logic        busy,
   input wire logic        waitingTrig
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Steps
   // ----------------------------------------
   sequence sPop;
      sampleAValid && sampleAReady;
   endsequence
   sequence sTake;
      cmdValid && cmdReady;
   endsequence
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   AST_DAC_MAP: assert property (sPop ##0 !sampleBReady |=>
      dacCode_q == {~$past(sampleA[15]), $past(sampleA[14:2])}) else $error("dac map wrong");
   AST_MARK_OR: assert property (sPop ##0 sampleBReady |=>
      (markers_q & ~$past(sampleA[1:0] | sampleB[1:0])) == 2'h0) else $error("marker merge wrong");
   AST_OUT_ALIGN: assert property (sPop |=> sampleValid_q) else $error("sample lost");
   AST_SET_TRIG: assert property (sTake ##0 cmdOp == `WMP_OP_SET_TRIG_OUTPUTS |=>
      trigOut_q == $past(cmdArg[3:0])) else $error("trigger outputs wrong");
   AST_TRIG_HOLD: assert property (!(cmdValid && cmdReady) |=> $stable(trigOut_q))
      else $error("trigger outputs moved");
   AST_WAIT_ENTER: assert property (sTake ##0 cmdOp == `WMP_OP_WAIT_DIG_TRIGGER |=>
      waitingTrig) else $error("wait not entered");
   AST_WAIT_STALL: assert property (waitingTrig |-> !cmdReady) else $error("stall broken");
   AST_PLAY_BUSY: assert property (sTake ##0 cmdOp == `WMP_OP_PLAY_WAVEFORM
      && cmdArg[11:0] != 12'h000 |=> busy) else $error("play not started");
endmodule
`default_nettype wire

// ### testbench/wmp_playback_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wmp_playback_consts.vh"
module wmp_playback_tb;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        cmdValid = 1'b0;
   logic [1:0]  cmdOp = 2'h0;
   logic [15:0] cmdArg = 16'h0000;
   logic [15:0] sampleA = 16'h0000;
   logic [15:0] sampleB = 16'h0000;
   logic        sampleAValid = 1'b0;
   logic        sampleBValid = 1'b0;
   wire  [7:0]  trigSources;
   wire         cmdReady, sampleAReady, sampleBReady, busy, waitingTrig, sampleValid_q;
   wire  [13:0] dacCode_q;
   wire  [1:0]  markers_q;
   wire  [3:0]  trigOut_q;
   logic [15:0] srcA[$], srcB[$], expQ[$];
   int          err_total = 0, checks = 0, cyc = 0, nOut = 0, nRise = 0;
   logic        prevV = 1'b0;
   logic        clkEn = 1'b1;
   logic [3:0]  trigFalling = 4'h0;
   logic [15:0] expW;

   always #5 core_clk = ~core_clk;

   wmp_playback uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .cmdValid(cmdValid),
      .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdArg(cmdArg), .sampleA(sampleA),
      .sampleAValid(sampleAValid), .sampleAReady(sampleAReady), .sampleB(sampleB),
      .sampleBValid(sampleBValid), .sampleBReady(sampleBReady), .trigSources(trigSources),
      .trigSelect(12'h2ef), .trigFalling(trigFalling), .dacCode_q(dacCode_q),
      .markers_q(markers_q), .sampleValid_q(sampleValid_q), .trigOut_q(trigOut_q), .busy(busy),
      .waitingTrig(waitingTrig));
   wmp_trig_equip tg (.trigSources(trigSources));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic print_verdict;
      if (err_total == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Raw words reach both ends of the -1..+1 span
   function automatic logic [15:0] wd(input int i);
      return (i % 16 == 15) ? 16'hffff : 16'(i * 16'h1111);
   endfunction
   function automatic logic [13:0] an(input logic [15:0] w);
      return {~w[15], w[14:2]};
   endfunction
   task automatic load(input int n, input logic strip, input logic add);
      logic [15:0] a, b;
      logic signed [14:0] s;
      for (int i = 0; i < n; i++) begin
         a = wd(i);
         b = wd((i < 2 || i == 15) ? i : i + 1);
         s = $signed(an(a)) + $signed(an(b));
         srcA.push_back(a);
         if (add) srcB.push_back(b);
         if (!add) expQ.push_back({an(a), strip ? 2'h0 : a[1:0]});
         else expQ.push_back({s > 8191 ? 14'h1fff : s < -8192 ? 14'h2000 : s[13:0],
                              a[1:0] | b[1:0]});
      end
   endtask
   // Leaves the request up so back-to-back commands need no idle edge
   task automatic send(input logic [1:0] op, input logic [15:0] arg);
      cmdOp <= op;
      cmdArg <= arg;
      cmdValid <= 1'b1;
      // Ready is judged at the rising edge where the design takes the request
      @(posedge core_clk);
      while (!cmdReady) @(posedge core_clk);
      @(negedge core_clk);
   endtask
   task automatic stop;
      cmdValid <= 1'b0;
      @(negedge core_clk);
   endtask
   task automatic idle;
      while (busy || sampleValid_q) @(negedge core_clk);
   endtask

   // ----------------------------------------
   // Stream source and output monitor
   // ----------------------------------------
   always @(negedge core_clk) begin
      sampleAValid <= srcA.size() > 0;
      sampleBValid <= srcB.size() > 0;
      sampleA <= srcA.size() > 0 ? srcA[0] : ~sampleA;
      sampleB <= srcB.size() > 0 ? srcB[0] : ~sampleB;
   end
   always @(posedge core_clk) begin
      if (sampleAValid && sampleAReady) void'(srcA.pop_front());
      if (sampleBValid && sampleBReady) void'(srcB.pop_front());
      if (sampleValid_q) begin
         expW = expQ.size() ? expQ.pop_front() : 16'hxxxx;
         chk({dacCode_q, markers_q}, expW);
      end
      nOut += sampleValid_q;
      nRise += sampleValid_q && !prevV;
      prevV <= sampleValid_q;
      cyc++;
      if (cyc == 3000) begin
         err_total++;
         print_verdict;
      end
   end

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_play;
      nOut = 0;
      nRise = 0;
      load(32, 1'b0, 1'b0);
      send(`WMP_OP_PLAY_WAVEFORM, 16'h0001);
      send(`WMP_OP_PLAY_WAVEFORM, 16'h0001);
      send(`WMP_OP_SET_TRIG_OUTPUTS, 16'h0003);
      stop;
      chk(16'(busy), 16'h0001);
      chk(16'(trigOut_q), 16'h0003);
      idle;
      chk(16'(nOut), 16'h0020);
      chk(16'(nRise), 16'h0001);
   endtask
   task automatic t_strip;
      send(`WMP_OP_PLAY_WAVEFORM, 16'h0000);
      stop;
      chk(16'(busy), 16'h0000);
      load(16, 1'b1, 1'b0);
      send(`WMP_OP_PLAY_WAVEFORM, 16'h4001);
      send(`WMP_OP_WAIT_WAVE_DONE, 16'h0000);
      send(`WMP_OP_SET_TRIG_OUTPUTS, 16'h000a);
      stop;
      chk(16'(busy), 16'h0000);
      chk(16'(trigOut_q), 16'h000a);
      idle;
   endtask
   task automatic t_freeze;
      trigFalling <= 4'h1;
      tg.setLevel(7, 1'b1);
      repeat (4) @(negedge core_clk);
      send(`WMP_OP_WAIT_DIG_TRIGGER, 16'h0000);
      stop;
      clkEn <= 1'b0;
      tg.setLevel(7, 1'b0);
      repeat (6) @(negedge core_clk);
      chk(16'(waitingTrig), 16'h0001);
      clkEn <= 1'b1;
      repeat (5) @(negedge core_clk);
      chk(16'(waitingTrig), 16'h0000);
      clkEn <= 1'b0;
      @(negedge core_clk);
      chk(16'(cmdReady), 16'h0000);
      clkEn <= 1'b1;
      trigFalling <= 4'h0;
      @(negedge core_clk);
   endtask
   task automatic t_add;
      load(16, 1'b0, 1'b1);
      send(`WMP_OP_PLAY_WAVEFORM, 16'h8001);
      stop;
      idle;
      chk(16'(srcB.size()), 16'h0000);
   endtask
   task automatic t_trig;
      logic [3:0] pat[4] = '{4'h1, 4'h8, 4'h5, 4'h0};
      for (int c = 0; c < 4; c++) begin
         send(`WMP_OP_WAIT_DIG_TRIGGER, 16'(c));
         stop;
         tg.setLevel(6 - 2 * c, 1'b1);
         repeat (6) @(negedge core_clk);
         chk(16'(waitingTrig), 16'h0001);
         tg.setLevel(7 - 2 * c, 1'b1);
         repeat (5) @(negedge core_clk);
         chk(16'(waitingTrig), 16'h0000);
         tg.setLevel(6 - 2 * c, 1'b0);
         tg.setLevel(7 - 2 * c, 1'b0);
      end
      foreach (pat[k]) begin
         send(`WMP_OP_SET_TRIG_OUTPUTS, {12'h000, pat[k]});
         stop;
         chk(16'(trigOut_q), {12'h000, pat[k]});
      end
   endtask

   initial begin
      repeat (3) @(negedge core_clk);
      rst_n <= 1'b1;
      @(negedge core_clk);
      t_play;
      t_strip;
      t_add;
      t_trig;
      t_freeze;
      print_verdict;
   end
endmodule

bind wmp_playback wmp_playback_chk chk (.core_clk(core_clk), .rst_n(rst_n),
   .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdArg(cmdArg),
   .sampleA(sampleA), .sampleAValid(sampleAValid), .sampleAReady(sampleAReady),
   .sampleB(sampleB), .sampleBValid(sampleBValid), .sampleBReady(sampleBReady),
   .dacCode_q(dacCode_q), .markers_q(markers_q), .sampleValid_q(sampleValid_q),
   .trigOut_q(trigOut_q), .busy(busy), .waitingTrig(waitingTrig));
`default_nettype wire

// ### testbench/wmp_trig_equip.sv
`timescale 1ns/1ps
`default_nettype none
module wmp_trig_equip (
   output logic [7:0] trigSources
);
   // Idle low; edges only on command
   initial trigSources = 8'h00;
   // One line per connector or internal unit
   task automatic setLevel(input int idx, input logic lvl);
      trigSources[idx] = lvl;
   endtask
endmodule
`default_nettype wire
